// ===== core/bfr_ctrl.sv
/*
 * bias fault response controller: diagnostic configuration registers,
 * per-fault debounce, threshold scaling and bias power-down/recovery
 * assumes comparator results and the sample strobe are synchronous to
 * ref_clk_i and that register accesses are single-cycle strobes
 */
`timescale 1ns/100ps
`include "bfr_map.svh"

module bfr_ctrl #(
   parameter int NUM_FLT = `BFR_NUM_FLT,
   parameter int CODE_W = 8
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_en_i,
   input wire logic [7:0] reg_wr_data_i,
   input wire logic reg_rd_en_i,
   output logic [7:0] reg_rd_data_o,
   output logic reg_rd_valid_o,
   // comparator results
   input wire logic sample_strobe_i,
   input wire logic [NUM_FLT-1:0] fault_raw_i,
   input wire logic battery_below_bias_i,
   // bias supply and fault state
   output logic bias_enable_o,
   output logic [NUM_FLT-1:0] fault_active_o,
   output logic [NUM_FLT-1:0] fault_event_o,
   output logic bias_recover_o,
   // applied thresholds
   output logic [CODE_W:0] bias_high_current_limit_o,
   output logic [CODE_W:0] bias_low_current_limit_o,
   output logic [CODE_W:0] aux_input_upper_limit_o,
   output logic [CODE_W:0] aux_input_lower_limit_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   // named copy of the reset value: a literal macro cannot be sliced directly
   localparam logic [7:0] DBNC_RST = `BFR_RST_DBNC;

   // configuration registers
   logic [3:0] dbnc_cfg_reg;
   logic [3:0] dbnc_cfg_next;
   logic [7:0] hicur_reg;
   logic [7:0] hicur_next;
   logic [7:0] locur_reg;
   logic [7:0] locur_next;
   logic [7:0] auxhi_reg;
   logic [7:0] auxhi_next;
   logic [7:0] auxlo_reg;
   logic [7:0] auxlo_next;
   logic [7:0] act_reg;
   logic [7:0] act_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic rd_valid_reg;
   logic rd_valid_next;

   logic [1:0] fault_debounce_select;
   logic battery_short_debounce;
   logic threshold_double_scale;
   logic manual_recovery_trigger;
   logic bias_auto_recovery_enable;
   logic bias_short_detect_disable;

   assign fault_debounce_select = dbnc_cfg_reg[`BFR_DBNC_SEL_MSB:`BFR_DBNC_SEL_LSB];
   assign battery_short_debounce = dbnc_cfg_reg[`BFR_BATT_DBNC_BIT];
   assign threshold_double_scale = dbnc_cfg_reg[`BFR_SCALE_BIT];
   assign manual_recovery_trigger = act_reg[`BFR_ACT_MAN_BIT];
   assign bias_auto_recovery_enable = act_reg[`BFR_ACT_AUTO_BIT];
   assign bias_short_detect_disable = act_reg[`BFR_ACT_SDIS_BIT];

   function automatic bfr_pkg::bfr_dbnc_cnt_t dbnc_len(input logic [1:0] sel);
      unique case (sel)
         2'h0: dbnc_len = `BFR_DBNC_CNT_16;
         2'h1: dbnc_len = `BFR_DBNC_CNT_8;
         2'h2: dbnc_len = `BFR_DBNC_CNT_4;
         2'h3: dbnc_len = `BFR_DBNC_CNT_NONE;
      endcase
   endfunction

   function automatic logic hit(input logic [7:0] ofs);
      hit = (reg_addr_i == ofs);
   endfunction

   // register writes; reserved fields have no storage at all
   always_comb begin
      dbnc_cfg_next = dbnc_cfg_reg;
      hicur_next = hicur_reg;
      locur_next = locur_reg;
      auxhi_next = auxhi_reg;
      auxlo_next = auxlo_reg;
      act_next = act_reg;
      act_next[`BFR_ACT_MAN_BIT] = 1'b0;
      if (reg_wr_en_i) begin
         if (hit(`BFR_OFS_DBNC)) begin
            dbnc_cfg_next = reg_wr_data_i[3:0];
         end
         if (hit(`BFR_OFS_HICUR)) begin
            hicur_next = reg_wr_data_i;
         end
         if (hit(`BFR_OFS_LOCUR)) begin
            locur_next = reg_wr_data_i;
         end
         if (hit(`BFR_OFS_AUXHI)) begin
            auxhi_next = reg_wr_data_i;
         end
         if (hit(`BFR_OFS_AUXLO)) begin
            auxlo_next = reg_wr_data_i;
         end
         if (hit(`BFR_OFS_ACT)) begin
            act_next = reg_wr_data_i;
         end
      end
   end

   // reads answer one cycle later; unmapped offsets return zero
   always_comb begin
      rd_valid_next = reg_rd_en_i;
      rd_data_next = 8'h00;
      if (reg_rd_en_i) begin
         unique case (reg_addr_i)
            `BFR_OFS_DBNC: rd_data_next = {DBNC_RST[7:4], dbnc_cfg_reg};
            `BFR_OFS_RSVD: rd_data_next = `BFR_RST_RSVD;
            `BFR_OFS_HICUR: rd_data_next = hicur_reg;
            `BFR_OFS_LOCUR: rd_data_next = locur_reg;
            `BFR_OFS_AUXHI: rd_data_next = auxhi_reg;
            `BFR_OFS_AUXLO: rd_data_next = auxlo_reg;
            `BFR_OFS_ACT: rd_data_next = act_reg;
            default: rd_data_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         dbnc_cfg_reg <= DBNC_RST[3:0];
         hicur_reg <= `BFR_RST_HICUR;
         locur_reg <= `BFR_RST_LOCUR;
         auxhi_reg <= `BFR_RST_AUXHI;
         auxlo_reg <= `BFR_RST_AUXLO;
         act_reg <= `BFR_RST_ACT;
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         dbnc_cfg_reg <= dbnc_cfg_next;
         hicur_reg <= hicur_next;
         locur_reg <= locur_next;
         auxhi_reg <= auxhi_next;
         auxlo_reg <= auxlo_next;
         act_reg <= act_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   assign reg_rd_data_o = rd_data_reg;
   assign reg_rd_valid_o = rd_valid_reg;

   // debounce: the battery short follows its own length only below the bias
   bfr_pkg::bfr_dbnc_cnt_t tgt [NUM_FLT];
   logic [NUM_FLT-1:0] raw_gated;
   logic [NUM_FLT-1:0] deb_act;
   logic [NUM_FLT-1:0] fault_act;
   logic [NUM_FLT-1:0] pd_en;

   always_comb begin
      for (int i = 0; i < NUM_FLT; i++) begin
         tgt[i] = dbnc_len(fault_debounce_select);
      end
      if (battery_below_bias_i) begin
         tgt[`BFR_FLT_BATT] = battery_short_debounce ? `BFR_DBNC_CNT_8 : `BFR_DBNC_CNT_16;
      end
      raw_gated = fault_raw_i;
      raw_gated[`BFR_FLT_SHORT] = fault_raw_i[`BFR_FLT_SHORT] & ~bias_short_detect_disable;
   end

   for (genvar g = 0; g < NUM_FLT; g++) begin : g_dbnc
      bfr_debounce #(
         .CNT_W(5)
      ) u_dbnc (
         .ref_clk_i(ref_clk_i),
         .reset_n_i(reset_n_i),
         .sample_i(sample_strobe_i),
         .raw_i(raw_gated[g]),
         .target_i(tgt[g]),
         .active_o(deb_act[g])
      );
   end

   // masking the accepted state too drops a short caught before the disable
   always_comb begin
      fault_act = deb_act;
      fault_act[`BFR_FLT_SHORT] = deb_act[`BFR_FLT_SHORT] & ~bias_short_detect_disable;
      pd_en = '0;
      pd_en[`BFR_FLT_SHORT] = act_reg[`BFR_ACT_SHORT_BIT];
      pd_en[`BFR_FLT_HIGH] = act_reg[`BFR_ACT_HIGH_BIT];
      pd_en[`BFR_FLT_LOW] = act_reg[`BFR_ACT_LOW_BIT];
      pd_en[`BFR_FLT_OV] = act_reg[`BFR_ACT_OV_BIT];
      pd_en[`BFR_FLT_OT] = act_reg[`BFR_ACT_OT_BIT];
   end

   // bias supply state
   bfr_pkg::bfr_bias_state_e state_reg;
   bfr_pkg::bfr_bias_state_e state_next;
   logic [NUM_FLT-1:0] cause_reg;
   logic [NUM_FLT-1:0] cause_next;
   logic [NUM_FLT-1:0] trip;
   logic [NUM_FLT-1:0] flt_out_reg;
   logic [NUM_FLT-1:0] flt_out_next;
   logic [NUM_FLT-1:0] evt_reg;
   logic [NUM_FLT-1:0] evt_next;
   logic bias_en_reg;
   logic bias_en_next;
   logic recover_reg;
   logic recover_next;

   assign trip = fault_act & pd_en;

   always_comb begin
      state_next = state_reg;
      cause_next = cause_reg;
      unique case (state_reg)
         bfr_pkg::BFR_BIAS_ON: begin
            if (|trip) begin
               state_next = bfr_pkg::BFR_BIAS_OFF;
               cause_next = trip;
            end
         end
         bfr_pkg::BFR_BIAS_OFF: begin
            cause_next = cause_reg | trip;
            if (manual_recovery_trigger && !(|trip)) begin
               state_next = bfr_pkg::BFR_BIAS_ON;
               cause_next = '0;
            end else if (bias_auto_recovery_enable && !(|(fault_act & (cause_reg | trip)))) begin
               state_next = bfr_pkg::BFR_BIAS_ON;
               cause_next = '0;
            end
         end
         default: begin
            state_next = bfr_pkg::BFR_BIAS_OFF;
            cause_next = '0;
         end
      endcase
      bias_en_next = (state_next == bfr_pkg::BFR_BIAS_ON);
      recover_next = (state_reg == bfr_pkg::BFR_BIAS_OFF) && bias_en_next;
      flt_out_next = fault_act;
      evt_next = fault_act & ~flt_out_reg;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state_reg <= bfr_pkg::BFR_BIAS_ON;
         cause_reg <= '0;
         bias_en_reg <= 1'b1;
         recover_reg <= 1'b0;
         flt_out_reg <= '0;
         evt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cause_reg <= cause_next;
         bias_en_reg <= bias_en_next;
         recover_reg <= recover_next;
         flt_out_reg <= flt_out_next;
         evt_reg <= evt_next;
      end
   end

   assign bias_enable_o = bias_en_reg;
   assign bias_recover_o = recover_reg;
   assign fault_active_o = flt_out_reg;
   assign fault_event_o = evt_reg;

   bfr_threshold #(
      .CODE_W(CODE_W)
   ) u_thr (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .scale_i(threshold_double_scale),
      .hicur_i(hicur_reg),
      .locur_i(locur_reg),
      .auxhi_i(auxhi_reg),
      .auxlo_i(auxlo_reg),
      .hicur_o(bias_high_current_limit_o),
      .locur_o(bias_low_current_limit_o),
      .auxhi_o(aux_input_upper_limit_o),
      .auxlo_o(aux_input_lower_limit_o)
   );

   property pd_p(logic f, logic en);
      (f && en && bias_en_reg) |=> !bias_en_reg;
   endproperty

   sequence man_req_s;
      manual_recovery_trigger && (state_reg == bfr_pkg::BFR_BIAS_OFF) && !(|trip);
   endsequence

   sequence bias_up_s;
      bias_en_reg ##0 recover_reg;
   endsequence

   dbnc_sel_a: assert property (
      (fault_debounce_select == 2'h2) |-> (tgt[`BFR_FLT_HIGH] == 5'h04))
      else $error("debounce length does not follow select");
   batt_dbnc_a: assert property (
      (battery_below_bias_i && battery_short_debounce) |-> (tgt[`BFR_FLT_BATT] == 5'h08))
      else $error("battery short debounce length wrong");
   thr_scale_a: assert property (
      threshold_double_scale && $stable(hicur_reg) && $stable(threshold_double_scale)
      |=> bias_high_current_limit_o == {$past(hicur_reg), 1'b0})
      else $error("high current limit not doubled");
   short_pd_a: assert property (pd_p(fault_act[`BFR_FLT_SHORT], pd_en[`BFR_FLT_SHORT]))
      else $error("short fault did not power the bias down");
   high_pd_a: assert property (pd_p(fault_act[`BFR_FLT_HIGH], pd_en[`BFR_FLT_HIGH]))
      else $error("high current fault did not power the bias down");
   low_pd_a: assert property (pd_p(fault_act[`BFR_FLT_LOW], pd_en[`BFR_FLT_LOW]))
      else $error("low current fault did not power the bias down");
   ov_pd_a: assert property (pd_p(fault_act[`BFR_FLT_OV], pd_en[`BFR_FLT_OV]))
      else $error("overvoltage fault did not power the bias down");
   ot_pd_a: assert property (pd_p(fault_act[`BFR_FLT_OT], pd_en[`BFR_FLT_OT]))
      else $error("overtemperature fault did not power the bias down");
   man_clear_a: assert property (
      manual_recovery_trigger && !(reg_wr_en_i && hit(`BFR_OFS_ACT))
      |=> !manual_recovery_trigger)
      else $error("manual recovery bit did not clear itself");
   man_recover_a: assert property (man_req_s |=> bias_up_s)
      else $error("manual recovery did not restore the bias");
   auto_recover_a: assert property (
      (state_reg == bfr_pkg::BFR_BIAS_OFF) && bias_auto_recovery_enable
      && !(|(fault_act & (cause_reg | trip))) |=> bias_up_s)
      else $error("auto recovery did not restore the bias");
   no_auto_a: assert property (
      (state_reg == bfr_pkg::BFR_BIAS_OFF) && !manual_recovery_trigger
      && !bias_auto_recovery_enable |=> !bias_en_reg)
      else $error("bias came back without a recovery request");
   short_dis_a: assert property (
      bias_short_detect_disable |=> !fault_active_o[`BFR_FLT_SHORT])
      else $error("short fault raised while detection disabled");
endmodule

// ===== core/bfr_debounce.sv
/*
 * one fault debouncer: the accepted state follows the raw comparator
 * only after target consecutive disagreeing samples
 * assumes sample_i is a one-cycle strobe in the ref_clk_i domain
 */
`timescale 1ns/100ps
module bfr_debounce #(
   parameter int CNT_W = 5
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // detection samples
   input wire logic sample_i,
   input wire logic raw_i,
   input wire logic [CNT_W-1:0] target_i,
   // accepted state
   output logic active_o
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic act_reg;
   logic act_next;
   logic [CNT_W-1:0] inc;

   always_comb begin
      inc = CNT_W'(cnt_reg + 1'b1);
      cnt_next = cnt_reg;
      act_next = act_reg;
      if (sample_i) begin
         if (raw_i == act_reg) begin
            cnt_next = '0;
         end else if (inc >= target_i) begin
            act_next = raw_i;
            cnt_next = '0;
         end else begin
            cnt_next = inc;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cnt_reg <= '0;
         act_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         act_reg <= act_next;
      end
   end

   assign active_o = act_reg;

   accept_cause_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(act_reg) |-> $past(sample_i) && $past(raw_i)
         && ($past(inc) >= $past(target_i)))
      else $error("fault accepted without a full run of samples");
   clear_restart_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (sample_i && !raw_i && !act_reg) |=> (cnt_reg == '0) && !act_reg)
      else $error("clear sample did not restart the count");
endmodule

// ===== core/bfr_map.svh
/*
 * register offsets, reset values, field positions and debounce counts
 * of the bias fault response block; definitions only, no logic
 */
`ifndef BFR_MAP_SVH
`define BFR_MAP_SVH

`define BFR_OFS_DBNC 8'h4A
`define BFR_OFS_RSVD 8'h4B
`define BFR_OFS_HICUR 8'h4C
`define BFR_OFS_LOCUR 8'h4D
`define BFR_OFS_AUXHI 8'h4E
`define BFR_OFS_AUXLO 8'h4F
`define BFR_OFS_ACT 8'h50

`define BFR_RST_DBNC 8'hB8
`define BFR_RST_RSVD 8'h00
`define BFR_RST_HICUR 8'hA2
`define BFR_RST_LOCUR 8'h48
`define BFR_RST_AUXHI 8'hBA
`define BFR_RST_AUXLO 8'h4B
`define BFR_RST_ACT 8'h88

`define BFR_DBNC_SEL_MSB 3
`define BFR_DBNC_SEL_LSB 2
`define BFR_BATT_DBNC_BIT 1
`define BFR_SCALE_BIT 0
`define BFR_DBNC_RO_MSB 7
`define BFR_DBNC_RO_LSB 4

`define BFR_ACT_SHORT_BIT 7
`define BFR_ACT_HIGH_BIT 6
`define BFR_ACT_LOW_BIT 5
`define BFR_ACT_OV_BIT 4
`define BFR_ACT_OT_BIT 3
`define BFR_ACT_MAN_BIT 2
`define BFR_ACT_AUTO_BIT 1
`define BFR_ACT_SDIS_BIT 0

`define BFR_DBNC_CNT_16 5'h10
`define BFR_DBNC_CNT_8 5'h08
`define BFR_DBNC_CNT_4 5'h04
`define BFR_DBNC_CNT_NONE 5'h01

`define BFR_FLT_SHORT 0
`define BFR_FLT_HIGH 1
`define BFR_FLT_LOW 2
`define BFR_FLT_OV 3
`define BFR_FLT_OT 4
`define BFR_FLT_BATT 5
`define BFR_FLT_AUXHI 6
`define BFR_FLT_AUXLO 7
`define BFR_NUM_FLT 8

`endif

// ===== core/bfr_pkg.sv
/*
 * types shared by the bias fault response block
 * assumes bfr_map.svh for the register, field and debounce constants; the bias state encodings are set here
 */
package bfr_pkg;
   typedef enum logic [1:0] {
      BFR_BIAS_ON = 2'b01,
      BFR_BIAS_OFF = 2'b10
   } bfr_bias_state_e;
   typedef logic [4:0] bfr_dbnc_cnt_t;
endpackage

// ===== core/bfr_threshold.sv
/*
 * applied diagnostic thresholds: each programmed code, optionally doubled
 * assumes codes and scale come from registers in the same clock domain
 */
`timescale 1ns/100ps
module bfr_threshold #(
   parameter int CODE_W = 8
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // programmed codes
   input wire logic scale_i,
   input wire logic [CODE_W-1:0] hicur_i,
   input wire logic [CODE_W-1:0] locur_i,
   input wire logic [CODE_W-1:0] auxhi_i,
   input wire logic [CODE_W-1:0] auxlo_i,
   // applied limits, one bit wider to hold the doubled code
   output logic [CODE_W:0] hicur_o,
   output logic [CODE_W:0] locur_o,
   output logic [CODE_W:0] auxhi_o,
   output logic [CODE_W:0] auxlo_o
);
   logic [4*(CODE_W+1)-1:0] lim_reg;
   logic [4*(CODE_W+1)-1:0] lim_next;

   function automatic logic [CODE_W:0] apply(input logic s, input logic [CODE_W-1:0] c);
      apply = s ? {c, 1'b0} : {1'b0, c};
   endfunction

   always_comb begin
      lim_next = {apply(scale_i, hicur_i), apply(scale_i, locur_i),
                  apply(scale_i, auxhi_i), apply(scale_i, auxlo_i)};
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         lim_reg <= '0;
      end else begin
         lim_reg <= lim_next;
      end
   end

   assign {hicur_o, locur_o, auxhi_o, auxlo_o} = lim_reg;
endmodule

// ===== tb/bfr_ctrl_test.sv
/*
 * self-checking bench for the bias fault response controller
 * assumes bfr_ctrl with default parameters; inputs change on falling edges
 */
`timescale 1ns/100ps
`include "bfr_map.svh"
module bfr_ctrl_test;
   localparam int LIMIT = 20000;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_en_i = 1'b0;
   logic [7:0] reg_wr_data_i = 8'h00;
   logic reg_rd_en_i = 1'b0;
   logic [7:0] reg_rd_data_o;
   logic reg_rd_valid_o;
   logic sample_strobe_i = 1'b0;
   logic [7:0] fault_raw_i = 8'h00;
   logic battery_below_bias_i = 1'b0;
   logic bias_enable_o;
   logic [7:0] fault_active_o;
   logic [7:0] fault_event_o;
   logic bias_recover_o;
   logic [8:0] hi_lim;
   logic [8:0] lo_lim;
   logic [8:0] up_lim;
   logic [8:0] dn_lim;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   logic [7:0] pd;
   logic [31:0] rng_state = 32'hF45811AB;
   logic [7:0] codes [4];

   always #5 ref_clk_i = ~ref_clk_i;

   bfr_ctrl dut_u (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_en_i(reg_wr_en_i),
      .reg_wr_data_i(reg_wr_data_i),
      .reg_rd_en_i(reg_rd_en_i),
      .reg_rd_data_o(reg_rd_data_o),
      .reg_rd_valid_o(reg_rd_valid_o),
      .sample_strobe_i(sample_strobe_i),
      .fault_raw_i(fault_raw_i),
      .battery_below_bias_i(battery_below_bias_i),
      .bias_enable_o(bias_enable_o),
      .fault_active_o(fault_active_o),
      .fault_event_o(fault_event_o),
      .bias_recover_o(bias_recover_o),
      .bias_high_current_limit_o(hi_lim),
      .bias_low_current_limit_o(lo_lim),
      .aux_input_upper_limit_o(up_lim),
      .aux_input_lower_limit_o(dn_lim)
   );

   function automatic logic [31:0] xorshift(logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   function automatic int dbn_len(logic [1:0] sel);
      case (sel)
         2'b00: return 16;
         2'b01: return 8;
         2'b10: return 4;
         default: return 1;
      endcase
   endfunction

   function automatic logic [8:0] applied(logic [7:0] code, logic scale);
      return scale ? {code, 1'b0} : {1'b0, code};
   endfunction

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cmp_val(logic [8:0] got, logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(logic got, logic exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(logic [7:0] addr, logic [7:0] data);
      @(negedge ref_clk_i);
      reg_addr_i = addr;
      reg_wr_data_i = data;
      reg_wr_en_i = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_en_i = 1'b0;
   endtask

   task automatic rd_chk(logic [7:0] addr, logic [7:0] exp);
      @(negedge ref_clk_i);
      reg_addr_i = addr;
      reg_rd_en_i = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_en_i = 1'b0;
      cmp_bit(reg_rd_valid_o, 1'b1);
      cmp_val({1'b0, reg_rd_data_o}, {1'b0, exp});
   endtask

   // n strobes of one raw value; raw flips after the last strobe, with the strobe low, which must be ignored
   task automatic samp(int idx, logic val, int cnt);
      for (int k = 0; k < cnt; k++) begin
         @(negedge ref_clk_i);
         sample_strobe_i = 1'b1;
         fault_raw_i[idx] = val;
      end
      @(negedge ref_clk_i);
      sample_strobe_i = 1'b0;
      fault_raw_i[idx] = ~val;
      @(negedge ref_clk_i);
   endtask

   // bounded wait for the recovery pulse; exp=0 means bias must stay off
   task automatic wait_rec(logic exp);
      int k;
      k = 0;
      while (bias_recover_o !== 1'b1 && k < 6) begin
         @(negedge ref_clk_i);
         k++;
      end
      cmp_bit(bias_recover_o, exp);
      cmp_bit(bias_enable_o, exp);
   endtask

   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      repeat (5) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      @(negedge ref_clk_i);
      cmp_val(hi_lim, 9'h0A2);
      cmp_val(lo_lim, 9'h048);
      cmp_val(up_lim, 9'h0BA);
      cmp_val(dn_lim, 9'h04B);
      cmp_bit(bias_enable_o, 1'b1);
      rd_chk(`BFR_OFS_DBNC, 8'hB8);
      rd_chk(`BFR_OFS_RSVD, 8'h00);
      rd_chk(`BFR_OFS_HICUR, 8'hA2);
      rd_chk(`BFR_OFS_LOCUR, 8'h48);
      rd_chk(`BFR_OFS_AUXHI, 8'hBA);
      rd_chk(`BFR_OFS_AUXLO, 8'h4B);
      rd_chk(`BFR_OFS_ACT, 8'h88);
      rd_chk(8'h60, 8'h00);
      wr(`BFR_OFS_RSVD, 8'hFF);
      rd_chk(`BFR_OFS_RSVD, 8'h00);
      wr(`BFR_OFS_DBNC, 8'h4F);
      rd_chk(`BFR_OFS_DBNC, 8'hBF);
      $display("test registers finished");

      // random codes, the full-scale code in the doubled pass
      for (int s = 0; s < 2; s++) begin
         for (int r = 0; r < 4; r++) begin
            rng_state = xorshift(rng_state);
            codes[r] = (s == 1 && r == 0) ? 8'hFF : rng_state[7:0];
            wr(8'(`BFR_OFS_HICUR + r), codes[r]);
         end
         wr(`BFR_OFS_DBNC, {7'h00, s[0]});
         repeat (2) @(negedge ref_clk_i);
         cmp_val(hi_lim, applied(codes[0], s[0]));
         cmp_val(lo_lim, applied(codes[1], s[0]));
         cmp_val(up_lim, applied(codes[2], s[0]));
         cmp_val(dn_lim, applied(codes[3], s[0]));
         for (int r = 0; r < 4; r++) begin
            rd_chk(8'(`BFR_OFS_HICUR + r), codes[r]);
         end
      end
      $display("test thresholds finished");

      wr(`BFR_OFS_ACT, 8'h40);
      for (int sel = 0; sel < 4; sel++) begin
         n = dbn_len(sel[1:0]);
         wr(`BFR_OFS_DBNC, {4'h0, sel[1:0], 2'b00});
         samp(1, 1'b1, n - 1);
         cmp_bit(fault_active_o[1], 1'b0);
         cmp_bit(bias_enable_o, 1'b1);
         samp(1, 1'b1, 1);
         cmp_bit(fault_active_o[1], 1'b1);
         cmp_bit(fault_event_o[1], 1'b1);
         cmp_bit(bias_enable_o, 1'b0);
         if (sel == 0) begin
            wr(`BFR_OFS_ACT, 8'h44);
            wait_rec(1'b0);
         end
         samp(1, 1'b0, n);
         cmp_bit(fault_active_o[1], 1'b0);
         if (sel == 0) begin
            wait_rec(1'b0);
         end
         wr(`BFR_OFS_ACT, 8'h44);
         wait_rec(1'b1);
      end
      wr(`BFR_OFS_DBNC, 8'h08);
      samp(1, 1'b1, 3);
      samp(1, 1'b0, 1);
      samp(1, 1'b1, 3);
      cmp_bit(fault_active_o[1], 1'b0);
      samp(1, 1'b1, 1);
      cmp_bit(fault_active_o[1], 1'b1);
      samp(1, 1'b0, 4);
      wr(`BFR_OFS_ACT, 8'h44);
      wait_rec(1'b1);
      $display("test debounce finished");

      wr(`BFR_OFS_DBNC, 8'h0C);
      for (int i = 0; i < 5; i++) begin
         for (int en = 0; en < 2; en++) begin
            pd = (en == 1) ? (8'h80 >> i) : 8'h00;
            wr(`BFR_OFS_ACT, pd | 8'h02);
            samp(i, 1'b1, 1);
            cmp_bit(fault_active_o[i], 1'b1);
            cmp_bit(bias_enable_o, ~en[0]);
            samp(i, 1'b0, 1);
            if (en == 1) begin
               wait_rec(1'b1);
            end else begin
               cmp_bit(bias_enable_o, 1'b1);
            end
         end
      end
      wr(`BFR_OFS_ACT, 8'h81);
      samp(0, 1'b1, 1);
      cmp_bit(fault_active_o[0], 1'b0);
      cmp_bit(bias_enable_o, 1'b1);
      samp(0, 1'b0, 1);
      $display("test power down finished");

      battery_below_bias_i = 1'b1;
      for (int b = 0; b < 2; b++) begin
         n = (b == 1) ? 8 : 16;
         wr(`BFR_OFS_DBNC, {4'h0, 2'b11, b[0], 1'b0});
         samp(5, 1'b1, n - 1);
         cmp_bit(fault_active_o[5], 1'b0);
         samp(5, 1'b1, 1);
         cmp_bit(fault_active_o[5], 1'b1);
         samp(5, 1'b0, n);
         cmp_bit(fault_active_o[5], 1'b0);
      end
      battery_below_bias_i = 1'b0;
      samp(5, 1'b1, 1);
      cmp_bit(fault_active_o[5], 1'b1);
      samp(5, 1'b0, 1);
      $display("test battery finished");
      wrap_up();
   end
endmodule
